//--- include/mrc_cfg.svh
// constants of the remote command handler: offsets, fields, characters, timing
`ifndef MRC_CFG_SVH
`define MRC_CFG_SVH

// register byte offsets
`define MRC_OFS_CMD 8'h00
`define MRC_OFS_CTRL 8'h04
`define MRC_OFS_STATUS 8'h08
`define MRC_OFS_CALFAC 8'h0C
`define MRC_OFS_SRQ 8'h10
`define MRC_OFS_DISPLAY 8'h14

// field positions
`define MRC_CTRL_RECALL 0
`define MRC_SRQ_PENDING 8

// command characters
`define MRC_CH_PWR 8'h50
`define MRC_CH_DB 8'h42
`define MRC_CH_CALFAC 8'h44
`define MRC_CH_AUTO 8'h41
`define MRC_CH_RHOLD 8'h4F
`define MRC_CH_HOLD 8'h51
`define MRC_CH_SRQ 8'h56
`define MRC_CH_RAW 8'h4A
`define MRC_CH_LIMIT 8'h55
`define MRC_CH_TRIG 8'h54
`define MRC_CH_D0 8'h30
`define MRC_CH_D9 8'h39

// bus address that is never recognised
`define MRC_ADDR_NONE 5'h1F

// timing: half period of the entry blink
`define MRC_PCLK_KHZ 20000
`define MRC_BLINK_HALF_MS 250

`endif

//--- include/mrc_cmd_if.sv
// carrier between the handler core and its character decoder
`timescale 1ns/1ps
interface mrc_cmd_if;
   logic [7:0] ch;
   logic ch_vld;
   logic clr;
   mrc_pkg::mrc_cmd_t cmd;
   logic [7:0] arg;
   logic has_arg;
   logic cmd_vld;
   logic pend;
   logic [7:0] acc;

   modport core (output ch, output ch_vld, output clr, input cmd, input arg, input has_arg,
                 input cmd_vld, input pend, input acc);
   modport dec (input ch, input ch_vld, input clr, output cmd, output arg, output has_arg,
                output cmd_vld, output pend, output acc);
endinterface

//--- include/mrc_pkg.sv
// types shared by the remote command handler modules
package mrc_pkg;
   typedef enum logic [1:0] {
      ST_MEAS = 2'b01,
      ST_ENTRY = 2'b10
   } mrc_state_t;

   typedef enum logic [3:0] {
      CMD_NONE, CMD_PWR, CMD_DB, CMD_CALFAC, CMD_AUTO, CMD_RHOLD,
      CMD_HOLD, CMD_SRQ, CMD_RAW, CMD_LIMIT, CMD_TRIG
   } mrc_cmd_t;

   typedef enum logic [1:0] {
      SRQ_OFF = 2'h0,
      SRQ_DONE = 2'h1,
      SRQ_SETTLED = 2'h2
   } mrc_srq_mode_t;
endpackage

//--- src/mrc_decode.sv
// command character decoder: gathers a numeric prefix and names the command letter
`timescale 1ns/1ps
`include "mrc_cfg.svh"
module mrc_decode (
   input wire logic pclk,
   input wire logic presetn,
   mrc_cmd_if.dec bus
);
   typedef struct packed {
      logic [7:0] acc;
      logic pend;
      mrc_pkg::mrc_cmd_t cmd;
      logic [7:0] arg;
      logic has_arg;
      logic vld;
   } mrc_dec_st_t;

   mrc_dec_st_t st_ff;
   mrc_dec_st_t nxt_st;
   logic [15:0] prod;

   // --------------------------------------------------------------
   // character decode
   // --------------------------------------------------------------
   always_comb begin
      nxt_st = st_ff;
      nxt_st.vld = 1'b0;
      prod = 16'(st_ff.acc) * 16'h000A + 16'(bus.ch - `MRC_CH_D0);
      if (bus.clr) begin
         nxt_st.acc = 8'h00;
         nxt_st.pend = 1'b0;
      end else if (bus.ch_vld) begin
         if (bus.ch >= `MRC_CH_D0 && bus.ch <= `MRC_CH_D9) begin
            // digits ahead of a letter form its argument; saturate, no wrap
            nxt_st.acc = (prod > 16'h00FF) ? 8'hFF : prod[7:0];
            nxt_st.pend = 1'b1;
         end else begin
            nxt_st.cmd = mrc_pkg::CMD_NONE;
            unique case (bus.ch)
               `MRC_CH_PWR: nxt_st.cmd = mrc_pkg::CMD_PWR;
               `MRC_CH_DB: nxt_st.cmd = mrc_pkg::CMD_DB;
               `MRC_CH_CALFAC: nxt_st.cmd = mrc_pkg::CMD_CALFAC;
               `MRC_CH_AUTO: nxt_st.cmd = mrc_pkg::CMD_AUTO;
               `MRC_CH_RHOLD: nxt_st.cmd = mrc_pkg::CMD_RHOLD;
               `MRC_CH_HOLD: nxt_st.cmd = mrc_pkg::CMD_HOLD;
               `MRC_CH_SRQ: nxt_st.cmd = mrc_pkg::CMD_SRQ;
               `MRC_CH_RAW: nxt_st.cmd = mrc_pkg::CMD_RAW;
               `MRC_CH_LIMIT: nxt_st.cmd = mrc_pkg::CMD_LIMIT;
               `MRC_CH_TRIG: nxt_st.cmd = mrc_pkg::CMD_TRIG;
               default: nxt_st.cmd = mrc_pkg::CMD_NONE;
            endcase
            // any non-digit ends the entry, unknown letters just drop it
            nxt_st.arg = st_ff.acc;
            nxt_st.has_arg = st_ff.pend;
            nxt_st.vld = (nxt_st.cmd != mrc_pkg::CMD_NONE);
            nxt_st.acc = 8'h00;
            nxt_st.pend = 1'b0;
         end
      end
   end

   // state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign bus.cmd = st_ff.cmd;
   assign bus.arg = st_ff.arg;
   assign bus.has_arg = st_ff.has_arg;
   assign bus.cmd_vld = st_ff.vld;
   assign bus.pend = st_ff.pend;
   assign bus.acc = st_ff.acc;
endmodule // mrc_decode

//--- src/mrc_top.sv
// remote command handler of the meter: APB registers, armable flags, display and service request
// How it works
// - exactly two states, measurement and data entry/recall, local or remote
// - entry state while digits pending or after recall, else measurement
// - talk data is only the displayed value
// - display blanks on and off while in entry or recall
// - P selects power/voltage display, B selects dBmV display
// - D takes its numeric prefix as calibration factor in dB
// - A selects autorange, O holds the present range
// - hold armed freezes the display, new readings are not taken in
// - hold armed asks the measurement engine for the short cycle
// - completion request flag raises service request on each finished reading
// - settled request flag raises service request only on settled reading
// - raw flag reports readings without averaging
// - limit flag raises service request on any exceeded limit
// - limit request disarms the limit flag until re-armed
// - T starts one measurement, same as group execute trigger
// - interface or device clear disarm all armable flags
// - bus address 31 is never recognised
// - request reason is a five-bit code, low and high per channel
`timescale 1ns/1ps
`include "mrc_cfg.svh"
module mrc_top #(
   parameter int BLINK_CYC = `MRC_BLINK_HALF_MS * `MRC_PCLK_KHZ,
   parameter int DISP_W = 16
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ren_pin,
   input wire logic ifc_pin,
   input wire logic dcl_pin,
   input wire logic get_pin,
   input wire logic [4:0] addr_sw,
   input wire logic [DISP_W-1:0] rd_value,
   input wire logic rd_done,
   input wire logic rd_settled,
   input wire logic [3:0] lim_hit,
   output logic meas_start,
   output logic meas_fast,
   output logic raw_mode,
   output logic db_mode,
   output logic auto_range,
   output logic [DISP_W-1:0] disp_value,
   output logic disp_blank,
   output logic addr_ok,
   output logic srq
);
   localparam int NSYNC = 9;
   localparam int BW = $clog2(BLINK_CYC + 1);

   // all state of the handler except the address check flop and the decoder instance is one record, registered in one place
   typedef struct packed {
      logic [NSYNC-1:0] sync1;
      logic [NSYNC-1:0] sync2;
      logic get_d;
      mrc_pkg::mrc_state_t state;
      logic recall;
      logic db;
      logic autor;
      logic [7:0] calfac;
      logic hold;
      mrc_pkg::mrc_srq_mode_t srq_mode;
      logic raw;
      logic limit;
      logic start;
      logic srq;
      logic [4:0] code;
      logic [DISP_W-1:0] reading;
      logic [DISP_W-1:0] disp;
      logic blank;
      logic [BW-1:0] bcnt;
      logic bphase;
      logic [7:0] ch;
      logic ch_vld;
      logic clr;
      logic rdy;
      logic [31:0] rdata;
      logic err;
   } mrc_st_t;

   mrc_st_t st_ff;
   mrc_st_t nxt_st;
   mrc_cmd_if cif ();

   // helpers below are pure decode of the registered state and the bus
   logic remote;
   logic ifc_s;
   logic dcl_s;
   logic get_s;
   logic [4:0] addr_s;
   logic acc_ok;
   logic wr_go;
   logic rd_go;
   logic bus_clr;
   logic trig;
   logic [4:0] lim_code;
   logic [31:0] rmux;
   logic rmap;

   // --------------------------------------------------------------
   // decoder instance
   // --------------------------------------------------------------
   mrc_decode u_dec (
      .pclk(pclk),
      .presetn(presetn),
      .bus(cif.dec)
   );

   // the decoder sees each accepted character for exactly one cycle
   assign cif.ch = st_ff.ch;
   assign cif.ch_vld = st_ff.ch_vld;
   assign cif.clr = st_ff.clr;

   // synchronised pin levels, only the second stage is read
   assign remote = st_ff.sync2[0];
   assign ifc_s = st_ff.sync2[1];
   assign dcl_s = st_ff.sync2[2];
   assign get_s = st_ff.sync2[3];
   assign addr_s = st_ff.sync2[8:4];

   // --------------------------------------------------------------
   // apb decode
   // --------------------------------------------------------------
   // one wait state: pready rises in the second access cycle, the transfer ends on the next edge
   assign acc_ok = psel && penable && st_ff.rdy;
   assign wr_go = acc_ok && pwrite;
   // the read word is captured in the first access cycle, so it stands with pready
   assign rd_go = psel && penable && !st_ff.rdy && !pwrite;
   assign bus_clr = ifc_s || dcl_s;

   // read mux, unmapped offsets answer with an error and zero data
   // status packs every flag so software sees the armed set in one read
   always_comb begin
      rmux = 32'h0000_0000;
      rmap = 1'b1;
      unique case (paddr)
         `MRC_OFS_CMD: rmux = 32'h0000_0000;
         `MRC_OFS_CTRL: rmux = {31'h0, st_ff.recall};
         `MRC_OFS_STATUS: rmux = {20'h0, st_ff.srq, addr_ok, remote, st_ff.limit, st_ff.raw,
                                  st_ff.srq_mode, st_ff.hold, st_ff.autor, st_ff.db, st_ff.state};
         `MRC_OFS_CALFAC: rmux = {24'h0, st_ff.calfac};
         `MRC_OFS_SRQ: rmux = {23'h0, st_ff.srq, 3'h0, st_ff.code};
         `MRC_OFS_DISPLAY: rmux = 32'(st_ff.disp);
         default: rmap = 1'b0;
      endcase
   end

   // limit reason: bits 1:0 channel one, bits 3:2 channel two, low then high
   assign lim_code = {1'b0, lim_hit[3], lim_hit[2], lim_hit[1], lim_hit[0]};

   // trigger from the bus: rising edge of group execute trigger or the T letter
   assign trig = (get_s && !st_ff.get_d && remote) ||
                 (cif.cmd_vld && cif.cmd == mrc_pkg::CMD_TRIG);

   // --------------------------------------------------------------
   // next state
   // --------------------------------------------------------------
   always_comb begin
      nxt_st = st_ff;
      // pins enter the first stage only, strobes fall back to idle each cycle
      nxt_st.sync1 = {addr_sw, get_pin, dcl_pin, ifc_pin, ren_pin};
      nxt_st.sync2 = st_ff.sync1;
      nxt_st.get_d = get_s;
      nxt_st.start = 1'b0;
      nxt_st.ch_vld = 1'b0;
      nxt_st.clr = bus_clr;

      // apb handshake
      nxt_st.rdy = psel && penable && !st_ff.rdy;
      nxt_st.err = psel && penable && !st_ff.rdy && !rmap;
      if (rd_go) begin
         nxt_st.rdata = rmap ? rmux : 32'h0000_0000;
      end else if (acc_ok) begin
         nxt_st.rdata = 32'h0000_0000;
      end

      // command characters reach the decoder only under remote control
      if (wr_go && paddr == `MRC_OFS_CMD && remote && !bus_clr) begin
         nxt_st.ch = pwdata[7:0];
         nxt_st.ch_vld = 1'b1;
      end
      // recall is a plain software bit, cleared again by the next recognised letter
      if (wr_go && paddr == `MRC_OFS_CTRL) begin
         nxt_st.recall = pwdata[`MRC_CTRL_RECALL];
      end

      // decoded commands, any accepted letter ends a recall
      // remote is checked again so an enable that drops after the write still wins
      if (cif.cmd_vld && remote) begin
         nxt_st.recall = 1'b0;
         unique case (cif.cmd)
            mrc_pkg::CMD_PWR: nxt_st.db = 1'b0;
            mrc_pkg::CMD_DB: nxt_st.db = 1'b1;
            mrc_pkg::CMD_CALFAC: nxt_st.calfac = cif.has_arg ? cif.arg : st_ff.calfac;
            mrc_pkg::CMD_AUTO: nxt_st.autor = 1'b1;
            mrc_pkg::CMD_RHOLD: nxt_st.autor = 1'b0;
            mrc_pkg::CMD_HOLD: nxt_st.hold = (cif.arg == 8'h01);
            mrc_pkg::CMD_SRQ: begin
               // prefix 1 arms on completion, 2 on settled, anything else disarms
               if (cif.arg == 8'h01) begin
                  nxt_st.srq_mode = mrc_pkg::SRQ_DONE;
               end else if (cif.arg == 8'h02) begin
                  nxt_st.srq_mode = mrc_pkg::SRQ_SETTLED;
               end else begin
                  nxt_st.srq_mode = mrc_pkg::SRQ_OFF;
               end
            end
            mrc_pkg::CMD_RAW: nxt_st.raw = (cif.arg == 8'h01);
            mrc_pkg::CMD_LIMIT: nxt_st.limit = (cif.arg == 8'h01);
            default: nxt_st.recall = 1'b0;
         endcase
      end
      if (trig) begin
         nxt_st.start = 1'b1;
      end

      // software clears the request, a new event in the same cycle still sets it
      if (wr_go && paddr == `MRC_OFS_SRQ && pwdata[`MRC_SRQ_PENDING]) begin
         nxt_st.srq = 1'b0;
         nxt_st.code = 5'h00;
      end
      // completion and settled reasons share code bit 4
      if (rd_done && st_ff.srq_mode == mrc_pkg::SRQ_DONE) begin
         nxt_st.srq = 1'b1;
         nxt_st.code = nxt_st.code | 5'h10;
      end
      if (rd_settled && st_ff.srq_mode == mrc_pkg::SRQ_SETTLED) begin
         nxt_st.srq = 1'b1;
         nxt_st.code = nxt_st.code | 5'h10;
      end
      // a limit alarm disarms itself, the controller has to re-arm it
      if (st_ff.limit && lim_hit != 4'h0) begin
         nxt_st.srq = 1'b1;
         nxt_st.code = nxt_st.code | lim_code;
         nxt_st.limit = 1'b0;
      end

      // clears win over arming: the flags stay down while the clear lasts
      if (bus_clr) begin
         nxt_st.hold = 1'b0;
         nxt_st.srq_mode = mrc_pkg::SRQ_OFF;
         nxt_st.raw = 1'b0;
         nxt_st.limit = 1'b0;
      end

      // readings are not captured under hold, so the stored reading and the shown value both freeze
      if (rd_done && !st_ff.hold) begin
         nxt_st.reading = rd_value;
      end

      // operating state follows digit entry and recall
      if (cif.pend || st_ff.recall) begin
         nxt_st.state = mrc_pkg::ST_ENTRY;
      end else begin
         nxt_st.state = mrc_pkg::ST_MEAS;
      end

      // display source: entry shows the digits or the recalled factor
      unique case (st_ff.state)
         mrc_pkg::ST_ENTRY: begin
            // a letter after digits leaves the last entry shown, only recall brings up the factor
            if (cif.pend) begin
               nxt_st.disp = DISP_W'(cif.acc);
            end else if (st_ff.recall) begin
               nxt_st.disp = DISP_W'(st_ff.calfac);
            end
         end
         mrc_pkg::ST_MEAS: begin
            if (!st_ff.hold) begin
               nxt_st.disp = nxt_st.reading;
            end
         end
         default: nxt_st.disp = st_ff.disp;
      endcase

      // blink divider runs free, so the first phase of a blink can be shorter than BLINK_CYC cycles
      if (st_ff.bcnt == BW'(BLINK_CYC - 1)) begin
         nxt_st.bcnt = '0;
         nxt_st.bphase = !st_ff.bphase;
      end else begin
         nxt_st.bcnt = st_ff.bcnt + BW'(1);
      end
      // only the entry state blanks, so a measured value is never hidden
      nxt_st.blank = (st_ff.state == mrc_pkg::ST_ENTRY) && st_ff.bphase;
   end

   // --------------------------------------------------------------
   // state register
   // --------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // wake up measuring with autorange and every flag disarmed
         st_ff <= '0;
         st_ff.state <= mrc_pkg::ST_MEAS;
         st_ff.autor <= 1'b1;
         st_ff.srq_mode <= mrc_pkg::SRQ_OFF;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // address switch check, registered so the output comes from a flop
   // an all-ones switch setting only drops addr_ok, the handler still takes commands and triggers from the bus
   logic addr_ok_ff;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr_ok_ff <= 1'b0;
      end else begin
         addr_ok_ff <= (addr_s != `MRC_ADDR_NONE);
      end
   end

   // --------------------------------------------------------------
   // outputs
   // --------------------------------------------------------------
   // bus answer
   assign prdata = st_ff.rdata;
   assign pready = st_ff.rdy;
   assign pslverr = st_ff.err;

   // measurement engine controls
   assign meas_start = st_ff.start;
   assign meas_fast = st_ff.hold;
   assign raw_mode = st_ff.raw;
   assign db_mode = st_ff.db;
   assign auto_range = st_ff.autor;

   // front panel and bus status
   assign disp_value = st_ff.disp;
   assign disp_blank = st_ff.blank;
   assign addr_ok = addr_ok_ff;
   assign srq = st_ff.srq;
endmodule // mrc_top

//--- test/mrc_engine_model.sv
// measurement engine model facing the command handler
`timescale 1ns/1ps
module mrc_engine_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic meas_start,
   input wire logic stl_en,
   input wire logic [3:0] lim_req,
   output logic [15:0] rd_value,
   output logic rd_done,
   output logic rd_settled,
   output logic [3:0] lim_hit
);
   logic [2:0] cnt_ff;
   // ------------------------------
   // one reading a few cycles after each start
   // ------------------------------
   // the value moves every reading so a frozen display is told apart
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_ff <= 3'h0;
         rd_value <= 16'h1000;
         rd_done <= 1'b0;
         rd_settled <= 1'b0;
      end else begin
         rd_done <= 1'b0;
         rd_settled <= 1'b0;
         if (meas_start) begin
            cnt_ff <= 3'h3;
         end else if (cnt_ff != 3'h0) begin
            cnt_ff <= cnt_ff - 3'h1;
            if (cnt_ff == 3'h1) begin
               rd_done <= 1'b1;
               rd_settled <= stl_en; // settling only when the bench allows it
               rd_value <= rd_value + 16'h0111;
            end
         end
      end
   end
   assign lim_hit = lim_req; // limit compare result, level per cycle
endmodule // mrc_engine_model

//--- test/mrc_top_properties.sv
// port checker of the remote command handler
`timescale 1ns/1ps
module mrc_top_properties (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic ifc_pin,
   input wire logic dcl_pin,
   input wire logic [4:0] addr_sw,
   input wire logic addr_ok,
   input wire logic meas_start,
   input wire logic meas_fast,
   input wire logic raw_mode,
   input wire logic srq,
   input wire logic rd_done,
   input wire logic rd_settled,
   input wire logic [3:0] lim_hit
);
   // ------------------------------
   // bus timing and flag checks
   // ------------------------------
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   ready_pulse_a: assert property (pready |=> !pready) else $error("ready held");
   one_wait_a: assert property (psel && $rose(penable) |-> !pready ##1 pready) else $error("wait state");
   err_with_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
   addr_none_a: assert property (addr_sw == 5'h1F [*4] |-> !addr_ok) else $error("address 31 seen");
   ifc_disarm_a: assert property (ifc_pin [*4] |-> !meas_fast && !raw_mode) else $error("ifc flags");
   dcl_disarm_a: assert property (dcl_pin [*4] |-> !meas_fast && !raw_mode) else $error("dcl flags");
   start_once_a: assert property (meas_start |=> !meas_start) else $error("start too long");
   srq_cause_a: assert property ($rose(srq) |-> $past(rd_done || rd_settled || (|lim_hit)))
      else $error("srq without cause");
   cover property ($rose(srq));
   cover property (meas_start);
   cover property (pslverr);
endmodule // mrc_top_properties
bind mrc_top mrc_top_properties u_mrc_top_properties (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
   .ifc_pin, .dcl_pin, .addr_sw, .addr_ok, .meas_start, .meas_fast, .raw_mode, .srq, .rd_done, .rd_settled,
   .lim_hit);

//--- test/mrc_top_tb.sv
// testbench of the remote command handler
`timescale 1ns/1ps
`include "mrc_cfg.svh"
module mrc_top_tb;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic ren_pin = 1, ifc_pin = 0, dcl_pin = 0, get_pin = 0, stl_en = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic pready, pslverr, e, rd_done, rd_settled, meas_start, meas_fast, raw_mode;
   logic db_mode, auto_range, disp_blank, addr_ok, srq;
   logic [4:0] addr_sw = 5'h10;
   logic [15:0] rd_value, disp_value, d0;
   logic [3:0] lim_hit, lim_req = 4'h0;
   int err_total = 0, checks_done = 0, starts = 0, s;
   mrc_top #(.BLINK_CYC(8)) u_mrc_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .ren_pin, .ifc_pin, .dcl_pin, .get_pin, .addr_sw, .rd_value, .rd_done, .rd_settled,
      .lim_hit, .meas_start, .meas_fast, .raw_mode, .db_mode, .auto_range, .disp_value, .disp_blank, .addr_ok,
      .srq);
   mrc_engine_model u_mrc_engine_model (.pclk, .presetn, .meas_start, .stl_en, .lim_req, .rd_value, .rd_done,
      .rd_settled, .lim_hit);
   // ------------------------------
   // clock, start counter, tasks
   // ------------------------------
   initial forever #25 pclk = ~pclk;
   always @(posedge pclk) if (meas_start === 1'b1) starts <= starts + 1;
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task test_done;
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task hang(input int n);
      if (n >= 60) begin
         err_total++;
         $display("wrong value at %0t: wait ran out", $time);
         test_done;
      end
   endtask
   // one apb transfer; read data and error land in q and e
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 60);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      hang(n);
      @(posedge pclk); // idle cycle so the next setup never lands in the same step
   endtask
   // a command acts two edges after its write completes
   task send(input logic [7:0] c);
      apb(1'b1, `MRC_OFS_CMD, {24'h0, c});
      repeat (3) @(posedge pclk);
   endtask
   task arm(input int n, input logic [7:0] c);
      send(`MRC_CH_D0 + 8'(n));
      send(c);
   endtask
   task trig;
      int n;
      n = 0;
      s = starts;
      send(`MRC_CH_TRIG);
      while (starts == s && n < 60) begin @(posedge pclk); n++; end
      hang(n);
      repeat (8) @(posedge pclk);
   endtask
   task clr_pin(input bit dev);
      arm(1, `MRC_CH_HOLD);
      arm(1, `MRC_CH_RAW);
      arm(1, `MRC_CH_SRQ);
      arm(1, `MRC_CH_LIMIT);
      if (dev) dcl_pin <= 1'b1;
      else ifc_pin <= 1'b1;
      repeat (5) @(posedge pclk);
      chk(meas_fast, 0);
      chk(raw_mode, 0);
      apb(1'b0, `MRC_OFS_STATUS, 0);
      chk(q[8:4], 0);
      ifc_pin <= 1'b0;
      dcl_pin <= 1'b0;
      repeat (4) @(posedge pclk);
   endtask
   initial begin
      repeat (20000) @(posedge pclk);
      hang(60);
   end
   // ------------------------------
   // main sequence
   // ------------------------------
   initial begin
      int n;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
      chk(auto_range, 1);
      apb(1'b0, `MRC_OFS_STATUS, 0);
      chk(q, 32'h609);
      apb(1'b0, 8'h18, 0);
      chk(e, 1);
      chk(q, 0);
      $display("test reset done");
      send(`MRC_CH_DB);
      chk(db_mode, 1);
      send(`MRC_CH_PWR);
      chk(db_mode, 0);
      send(`MRC_CH_RHOLD);
      chk(auto_range, 0);
      send(`MRC_CH_AUTO);
      chk(auto_range, 1);
      $display("test modes done");
      send(`MRC_CH_D0 + 8'h1);
      send(`MRC_CH_D0 + 8'h2);
      apb(1'b0, `MRC_OFS_STATUS, 0);
      chk(q[1:0], 2'b10);
      n = 0;
      while (disp_blank !== 1'b1 && n < 60) begin @(posedge pclk); n++; end
      chk(disp_blank, 1);
      send(`MRC_CH_CALFAC);
      apb(1'b0, `MRC_OFS_CALFAC, 0);
      chk(q, 32'd12);
      apb(1'b0, `MRC_OFS_STATUS, 0);
      chk(q[1:0], 2'b01);
      chk(disp_blank, 0);
      apb(1'b1, `MRC_OFS_CTRL, 32'h1);
      apb(1'b0, `MRC_OFS_STATUS, 0);
      chk(q[1:0], 2'b10);
      apb(1'b0, `MRC_OFS_DISPLAY, 0);
      chk(q, 32'd12);
      send(`MRC_CH_PWR);
      apb(1'b0, `MRC_OFS_STATUS, 0);
      chk(q[1:0], 2'b01);
      $display("test entry done");
      arm(1, `MRC_CH_HOLD);
      chk(meas_fast, 1);
      d0 = disp_value;
      trig;
      chk(disp_value, d0);
      arm(0, `MRC_CH_HOLD);
      trig;
      chk(disp_value, rd_value);
      apb(1'b0, `MRC_OFS_DISPLAY, 0);
      chk(q, {16'h0, rd_value});
      s = starts;
      get_pin <= 1'b1;
      repeat (10) @(posedge pclk);
      get_pin <= 1'b0;
      chk(starts, s + 1);
      $display("test hold and trigger done");
      arm(1, `MRC_CH_SRQ);
      trig;
      chk(srq, 1);
      apb(1'b0, `MRC_OFS_SRQ, 0);
      chk(q, 32'h110);
      apb(1'b1, `MRC_OFS_SRQ, 32'h100);
      apb(1'b0, `MRC_OFS_SRQ, 0);
      chk(q, 0);
      arm(2, `MRC_CH_SRQ);
      trig;
      chk(srq, 0);
      stl_en <= 1'b1;
      trig;
      chk(srq, 1);
      apb(1'b1, `MRC_OFS_SRQ, 32'h100);
      arm(0, `MRC_CH_SRQ);
      arm(1, `MRC_CH_LIMIT);
      lim_req <= 4'h4;
      repeat (4) @(posedge pclk);
      chk(srq, 1);
      apb(1'b0, `MRC_OFS_SRQ, 0);
      chk(q, 32'h104);
      apb(1'b0, `MRC_OFS_STATUS, 0);
      chk(q[8], 0);
      apb(1'b1, `MRC_OFS_SRQ, 32'h100);
      repeat (4) @(posedge pclk);
      chk(srq, 0);
      lim_req <= 4'h0;
      $display("test service request done");
      arm(1, `MRC_CH_RAW);
      chk(raw_mode, 1);
      clr_pin(0);
      clr_pin(1);
      $display("test clears done");
      ren_pin <= 1'b0;
      repeat (4) @(posedge pclk);
      send(`MRC_CH_DB);
      chk(db_mode, 0);
      ren_pin <= 1'b1;
      repeat (4) @(posedge pclk);
      send(`MRC_CH_DB);
      chk(db_mode, 1);
      addr_sw <= 5'h1F;
      repeat (5) @(posedge pclk);
      chk(addr_ok, 0);
      addr_sw <= 5'h1E;
      repeat (5) @(posedge pclk);
      chk(addr_ok, 1);
      $display("test remote and address done");
      test_done;
   end
endmodule // mrc_top_tb
